// [pkg/bridge_cfg_defs.svh]
// offsets, field positions, reset values and codes of the primary status and class block
`ifndef BRIDGE_CFG_DEFS_SVH
`define BRIDGE_CFG_DEFS_SVH

`define CFG_OFF_STATUS        8'h04
`define CFG_OFF_CLASS         8'h08
`define CFG_OFF_LINE          8'h0C
`define CFG_DWORD_MASK        8'hFC

`define STS_RSVD_LO_BITS      4'h0
`define STS_EXT_CAP_BIT       20
`define STS_SPEED_BIT         21
`define STS_RSVD_22_BIT       22
`define STS_FAST_B2B_BIT      23
`define STS_MASTER_PAR_BIT    24
`define STS_DECODE_LO_BIT     25
`define STS_DECODE_HI_BIT     26
`define STS_FLAG_HI_LSB       27
`define STS_FLAG_HI_MSB       31

`define STS_EXT_CAP_VAL       1'h1
`define STS_FAST_B2B_VAL      1'h1
`define STS_RSVD_22_VAL       1'h0
`define STS_DECODE_VAL        2'h1

`define FLAG_COUNT            6
`define FLAG_MASTER_PAR       0
`define FLAG_SIG_TGT_ABORT    1
`define FLAG_RCV_TGT_ABORT    2
`define FLAG_RCV_MST_ABORT    3
`define FLAG_SIG_SYS_ERR      4
`define FLAG_DET_PAR_ERR      5
`define FLAG_RESET_VAL        6'h00

`define PROG_IF_CODE          8'h00
`define SUBCLASS_CODE         8'h04
`define BASE_CLASS_CODE       8'h06
`define REVISION_DEFAULT      8'h01

`define LINE_RESET_VAL        8'h00
`define LINE_MAX_WORDS        8'h10
`define LINE_EFF_MAX          5'h10

`define LANE_0                0
`define LANE_2                2
`define LANE_3                3
`define DATA_ZERO             32'h0000_0000
`define SYNC_RESET_VAL        2'h0

`endif

// [pkg/bridge_cfg_pkg.sv]
// types shared by the primary status and class block
package bridge_cfg_pkg;

	typedef enum logic [1:0] {
		ACC_IDLE   = 2'b01,
		ACC_ANSWER = 2'b10
	} acc_state_t;

	typedef logic [31:0] cfg_word_t;

endpackage : bridge_cfg_pkg

// [pkg/flag_if.sv]
// carrier between the register decoder and the sticky flag bank
interface flag_if #(
	parameter int N = 6
);
	logic [N-1:0] set;
	logic [N-1:0] clear;
	logic [N-1:0] flags;

	modport bank (input set, input clear, output flags);
	modport user (output set, output clear, input flags);
endinterface : flag_if

// [core/status_flag_bank.sv]
// sticky write-one-to-clear status flags
`include "bridge_cfg_defs.svh"

module status_flag_bank
	import bridge_cfg_pkg::*;
#(
	parameter int N = `FLAG_COUNT
) (
	input  wire logic clk,
	input  wire logic rst_n,
	flag_if.bank      fl
);

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			logic flag;
			wire  next_flag = fl.set[i] | (flag & ~fl.clear[i]);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					flag <= 1'b0;
				end else begin
					flag <= next_flag;
				end
			end
			assign fl.flags[i] = flag;
		end
	endgenerate

endmodule : status_flag_bank

// [core/bridge_primary_status_and_class_regs.sv]
// primary status upper half, class code bytes and line length register
// Overview of operation
// - status bits 19:16 and 22 read zero
// - status bit 20 always reads one
// - status bit 21 follows the speed strap
// - status bit 23 always reads one
// - bit 24 set on master parity error, enabled
// - status bits 26:25 read 01b
// - bit 27 set on signaled target abort
// - bit 28 set on received target abort
// - bit 29 set on received master abort
// - bit 30 set when system error driven
// - bit 31 set on detected parity error, not on the parity pin
// - revision byte fixed, writes ignored
// - programming interface byte reads zero
// - subclass byte reads 0x04
// - base class byte reads 0x06
// - line length byte writable, resets zero
// - bad or oversize line length means 16
// - parity response gates parity pin and flag
`include "bridge_cfg_defs.svh"

module bridge_primary_status_and_class_regs
	import bridge_cfg_pkg::*;
#(
	parameter logic [7:0] REVISION = `REVISION_DEFAULT // arbitrary value
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        cfg_req,
	input  wire logic        cfg_write,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  primary_cmd_byte_enables_n,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic [31:0]      cfg_rdata,
	input  wire logic        speed_strap_pin,
	input  wire logic        parity_resp_enable,
	input  wire logic        master_active,
	input  wire logic        parity_err_detected,
	input  wire logic        target_abort_signaled,
	input  wire logic        target_abort_received,
	input  wire logic        master_abort_received,
	input  wire logic        system_error_driven,
	input  wire logic        perr_drive_req,
	input  wire logic        primary_parity_error_pin_n_in,
	output logic             primary_parity_error_pin_n_out,
	output logic             primary_parity_error_pin_oe,
	output logic [4:0]       line_words_eff
);

	// reset release through two flops
	logic [1:0] rst_sync;
	logic       rst_core_n;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= `SYNC_RESET_VAL;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_core_n = rst_sync[1];

	// access handshake
	acc_state_t state;
	acc_state_t next_state;
	wire        take_req = (state == ACC_IDLE) & cfg_req;

	always_comb begin
		case (state)
			ACC_IDLE:   next_state = cfg_req ? ACC_ANSWER : ACC_IDLE;
			ACC_ANSWER: next_state = ACC_IDLE;
			default:    next_state = ACC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state <= ACC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// address decode
	wire [7:0] dword_addr = cfg_addr & `CFG_DWORD_MASK;
	wire       hit_status = dword_addr == `CFG_OFF_STATUS;
	wire       hit_class  = dword_addr == `CFG_OFF_CLASS;
	wire       hit_line   = dword_addr == `CFG_OFF_LINE;
	wire       wr_take    = take_req & cfg_write;
	wire       wr_status3 = wr_take & hit_status & ~primary_cmd_byte_enables_n[`LANE_3];
	wire       wr_line0   = wr_take & hit_line & ~primary_cmd_byte_enables_n[`LANE_0];

	// speed strap level
	logic speed_strap;

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			speed_strap <= 1'b0;
		end else begin
			speed_strap <= speed_strap_pin;
		end
	end

	// sticky flags
	flag_if #(.N(`FLAG_COUNT)) flg ();

	wire perr_pin_seen = ~primary_parity_error_pin_n_in;
	wire master_par_ev = master_active & (perr_pin_seen | parity_err_detected)
			& parity_resp_enable;

	assign flg.set[`FLAG_MASTER_PAR]    = master_par_ev;
	assign flg.set[`FLAG_SIG_TGT_ABORT] = target_abort_signaled;
	assign flg.set[`FLAG_RCV_TGT_ABORT] = target_abort_received;
	assign flg.set[`FLAG_RCV_MST_ABORT] = master_abort_received;
	assign flg.set[`FLAG_SIG_SYS_ERR]   = system_error_driven;
	assign flg.set[`FLAG_DET_PAR_ERR]   = parity_err_detected;

	// write one clears, byte lane 3 only
	assign flg.clear = {`FLAG_COUNT{wr_status3}}
			& {cfg_wdata[`STS_FLAG_HI_MSB:`STS_FLAG_HI_LSB],
			   cfg_wdata[`STS_MASTER_PAR_BIT]};

	status_flag_bank #(
		.N (`FLAG_COUNT)
	) u_flags (
		.clk   (sys_clk),
		.rst_n (rst_core_n),
		.fl    (flg.bank)
	);

	// line length register
	logic [7:0] line_length_words;

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			line_length_words <= `LINE_RESET_VAL;
		end else if (wr_line0) begin
			line_length_words <= cfg_wdata[7:0];
		end
	end

	wire line_pow2   = (line_length_words != 8'h00)
			& ((line_length_words & (line_length_words - 8'h01)) == 8'h00);
	wire line_usable = line_pow2 & (line_length_words <= `LINE_MAX_WORDS);
	wire [4:0] next_line_eff = line_usable ? line_length_words[4:0] : `LINE_EFF_MAX;

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			line_words_eff <= `LINE_EFF_MAX;
		end else begin
			line_words_eff <= next_line_eff;
		end
	end

	// parity error pin drive, gated by response enable
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			primary_parity_error_pin_n_out <= 1'b1;
			primary_parity_error_pin_oe    <= 1'b0;
		end else begin
			primary_parity_error_pin_n_out <= ~(perr_drive_req & parity_resp_enable);
			primary_parity_error_pin_oe    <= perr_drive_req & parity_resp_enable;
		end
	end

	// read data assembly
	wire [5:0] fl = flg.flags;

	// flag bits by position
	wire flag_det_par  = fl[`FLAG_DET_PAR_ERR];
	wire flag_sys_err  = fl[`FLAG_SIG_SYS_ERR];
	wire flag_rcv_mst  = fl[`FLAG_RCV_MST_ABORT];
	wire flag_rcv_tgt  = fl[`FLAG_RCV_TGT_ABORT];
	wire flag_sig_tgt  = fl[`FLAG_SIG_TGT_ABORT];
	wire flag_mst_par  = fl[`FLAG_MASTER_PAR];

	wire [31:0] status_word = {
		flag_det_par,
		flag_sys_err,
		flag_rcv_mst,
		flag_rcv_tgt,
		flag_sig_tgt,
		`STS_DECODE_VAL,
		flag_mst_par,
		`STS_FAST_B2B_VAL,
		`STS_RSVD_22_VAL,
		speed_strap,
		`STS_EXT_CAP_VAL,
		`STS_RSVD_LO_BITS,
		16'h0000
	};

	wire [31:0] class_word = {
		`BASE_CLASS_CODE,
		`SUBCLASS_CODE,
		`PROG_IF_CODE,
		REVISION
	};
	wire [31:0] line_word  = {24'h000000, line_length_words};

	wire [31:0] read_word = hit_status ? status_word :
			hit_class ? class_word :
			hit_line ? line_word : `DATA_ZERO;

	// byte lanes not enabled read zero
	wire [31:0] lane_mask;

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign lane_mask[b*8 +: 8] = {8{~primary_cmd_byte_enables_n[b]}};
		end
	endgenerate

	wire        rd_take    = take_req & ~cfg_write;
	wire [31:0] next_rdata = rd_take ? (read_word & lane_mask) : `DATA_ZERO;

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= `DATA_ZERO;
		end else begin
			cfg_ack   <= take_req;
			cfg_rdata <= next_rdata;
		end
	end

endmodule : bridge_primary_status_and_class_regs

// [verification/bridge_cfg_props.sv]
// port checks for the status and class register block
module bridge_cfg_props (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        cfg_req,
	input wire logic        cfg_write,
	input wire logic [7:0]  cfg_addr,
	input wire logic [3:0]  primary_cmd_byte_enables_n,
	input wire logic        cfg_ack,
	input wire logic [31:0] cfg_rdata,
	input wire logic        perr_drive_req,
	input wire logic        parity_resp_enable,
	input wire logic        primary_parity_error_pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic tk = cfg_req && !cfg_ack;
	wire logic rd = tk && !cfg_write && primary_cmd_byte_enables_n == 4'h0;
	property p_ack; tk |=> cfg_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_nak; !tk |=> !cfg_ack; endproperty
	a_nak: assert property (p_nak) else $error("ack without request");
	property p_idle; !cfg_ack |-> cfg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data outside ack");
	property p_sts; rd && cfg_addr[7:2] == 6'h01 |=> cfg_rdata[26:25] == 2'h1 &&
		cfg_rdata[23:22] == 2'h2 && cfg_rdata[20:16] == 5'h10; endproperty
	a_sts: assert property (p_sts) else $error("status fixed bits");
	property p_cls; rd && cfg_addr[7:2] == 6'h02 |=> cfg_rdata[31:8] == 24'h060400; endproperty
	a_cls: assert property (p_cls) else $error("class bytes");
	property p_line; rd && cfg_addr[7:2] == 6'h03 |=> cfg_rdata[31:8] == 24'h0; endproperty
	a_line: assert property (p_line) else $error("line upper bytes");
	property p_off; !parity_resp_enable |=> !primary_parity_error_pin_oe; endproperty
	a_off: assert property (p_off) else $error("pin driven while off");
	property p_on; perr_drive_req && parity_resp_enable |=> primary_parity_error_pin_oe;
	endproperty
	a_on: assert property (p_on) else $error("pin not driven");
endmodule : bridge_cfg_props

// [verification/cfg_master_model.sv]
// configuration master on the register access port
module cfg_master_model (
	input  wire logic        sys_clk,
	input  wire logic        cfg_ack,
	input  wire logic [31:0] cfg_rdata,
	output logic             cfg_req,
	output logic             cfg_write,
	output logic [7:0]       cfg_addr,
	output logic [3:0]       primary_cmd_byte_enables_n,
	output logic [31:0]      cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{cfg_req, cfg_write, cfg_addr, primary_cmd_byte_enables_n, cfg_wdata} = '0;
	end
	task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] r, output logic ok);
		ok = 1'b0;
		r = 32'h0;
		@(posedge sys_clk);
		{cfg_req, cfg_write, cfg_addr, primary_cmd_byte_enables_n, cfg_wdata} <= {1'b1, w, a, b, d};
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge sys_clk);
			if (cfg_ack === 1'b1) begin
				r = cfg_rdata;
				ok = 1'b1;
			end
		end
		cfg_req <= 1'b0;
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
	endtask : access
endmodule : cfg_master_model

// [verification/tb_bridge_primary_status_and_class_regs.sv]
// self-checking bench for the status and class register block
`define TB_CMP(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_bridge_primary_status_and_class_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        speed_strap_pin = 1'b1;
	logic        parity_resp_enable = 1'b0;
	logic        master_active = 1'b0;
	logic        perr_drive_req = 1'b0;
	logic        ext_n = 1'b1;
	logic [4:0]  ev = 5'h0;
	logic [31:0] r;
	int          n_fail = 0;
	int          n_checks = 0;
	wire logic   cfg_req, cfg_write, cfg_ack, primary_parity_error_pin_n_out;
	wire logic   primary_parity_error_pin_oe;
	wire logic [7:0]  cfg_addr;
	wire logic [3:0]  primary_cmd_byte_enables_n;
	wire logic [31:0] cfg_wdata, cfg_rdata;
	wire logic [4:0]  line_words_eff;
	wire logic   pin_n = (primary_parity_error_pin_oe ? primary_parity_error_pin_n_out : 1'b1) & ext_n;
	always #25 sys_clk = ~sys_clk;
	cfg_master_model m (.sys_clk, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_write, .cfg_addr,
		.primary_cmd_byte_enables_n, .cfg_wdata);
	bridge_primary_status_and_class_regs #(.REVISION(REV)) DUT (.sys_clk, .rst_n, .cfg_req,
		.cfg_write, .cfg_addr, .primary_cmd_byte_enables_n, .cfg_wdata, .cfg_ack, .cfg_rdata,
		.speed_strap_pin, .parity_resp_enable, .master_active, .parity_err_detected(ev[4]),
		.target_abort_signaled(ev[0]), .target_abort_received(ev[1]),
		.master_abort_received(ev[2]), .system_error_driven(ev[3]), .perr_drive_req,
		.primary_parity_error_pin_n_in(pin_n), .primary_parity_error_pin_n_out,
		.primary_parity_error_pin_oe, .line_words_eff);
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		logic ok;
		m.access(w, a, b, d, r, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : acc
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 4'h0, 32'h0);
		`TB_CMP("rdata", e, r)
	endtask : rdc
	task automatic t_fixed;
		rdc(8'h04, 32'h02B0_0000);
		rdc(8'h08, {24'h060400, REV});
		rdc(8'h0C, 32'h0);
		acc(1'b1, 8'h08, 4'h0, 32'hFFFF_FFFF);
		acc(1'b1, 8'h04, 4'h0, 32'hFFFF_FFFF);
		rdc(8'h08, {24'h060400, REV});
		rdc(8'h04, 32'h02B0_0000);
		@(posedge sys_clk) speed_strap_pin <= 1'b0;
		rdc(8'h04, 32'h0290_0000);
	endtask : t_fixed
	task automatic t_flags;
		logic [31:0] e;
		for (int i = 0; i < 5; i++) begin
			e = 32'h0800_0000 << i;
			@(posedge sys_clk) ev <= 5'h1 << i;
			@(posedge sys_clk) ev <= 5'h0;
			rdc(8'h04, 32'h0290_0000 | e);
			acc(1'b1, 8'h04, 4'h7, 32'h0);
			rdc(8'h04, 32'h0290_0000 | e);
			fork
				acc(1'b1, 8'h04, 4'h7, e);
				begin
					@(posedge sys_clk) ev <= 5'h1 << i;
					@(posedge sys_clk) ev <= 5'h0;
				end
			join
			rdc(8'h04, 32'h0290_0000 | e);
			acc(1'b1, 8'h04, 4'h7, e);
			rdc(8'h04, 32'h0290_0000);
		end
		@(posedge sys_clk) {master_active, ext_n} <= 2'b10;
		@(posedge sys_clk) ext_n <= 1'b1;
		rdc(8'h04, 32'h0290_0000);
		@(posedge sys_clk) {parity_resp_enable, ext_n} <= 2'b10;
		@(posedge sys_clk) ext_n <= 1'b1;
		rdc(8'h04, 32'h0390_0000);
		acc(1'b1, 8'h04, 4'h7, 32'h0100_0000);
		rdc(8'h04, 32'h0290_0000);
	endtask : t_flags
	task automatic t_line;
		logic [7:0] v [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h20, 8'hFF};
		logic [4:0] x [9] = '{5'h10, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10, 5'h10, 5'h10};
		for (int i = 0; i < 9; i++) begin
			acc(1'b1, 8'h0C, 4'hE, {24'hABCDEF, v[i]});
			rdc(8'h0C, {24'h0, v[i]});
			`TB_CMP("line_words_eff", x[i], line_words_eff)
		end
		acc(1'b1, 8'h0C, 4'hF, 32'h0000_0004);
		rdc(8'h0C, 32'h0000_00FF);
	endtask : t_line
	task automatic t_pin;
		@(posedge sys_clk) {perr_drive_req, parity_resp_enable} <= 2'b10;
		repeat (2) @(posedge sys_clk);
		`TB_CMP("oe", 1'b0, primary_parity_error_pin_oe)
		@(posedge sys_clk) parity_resp_enable <= 1'b1;
		repeat (2) @(posedge sys_clk);
		`TB_CMP("pin", 2'b10, {primary_parity_error_pin_oe, primary_parity_error_pin_n_out})
		@(posedge sys_clk) perr_drive_req <= 1'b0;
	endtask : t_pin
	task automatic t_reset;
		@(posedge sys_clk) ev <= 5'h01;
		@(posedge sys_clk) ev <= 5'h00;
		@(posedge sys_clk) rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`TB_CMP("line_words_eff", 5'h10, line_words_eff)
		rdc(8'h04, 32'h0290_0000);
		rdc(8'h0C, 32'h0);
	endtask : t_reset
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`TB_CMP("line_words_eff", 5'h10, line_words_eff)
		t_fixed();
		t_flags();
		t_line();
		t_pin();
		t_reset();
		tally_and_finish();
	end
endmodule : tb_bridge_primary_status_and_class_regs
bind bridge_primary_status_and_class_regs bridge_cfg_props u_props (.sys_clk, .rst_n,
	.cfg_req, .cfg_write, .cfg_addr, .primary_cmd_byte_enables_n, .cfg_ack, .cfg_rdata,
	.perr_drive_req, .parity_resp_enable, .primary_parity_error_pin_oe);
